// ===== core/ltx_alu.sv
// operand combining and flag update unit
`timescale 1ns/10ps
module ltx_alu (
	ltx_alu_if.unit port
);
	import ltx_pkg::*;

	logic [BYTE_W-1:0] cmask_r;
	logic [BYTE_W-1:0] mask_r;
	logic [BYTE_W-1:0] xor_r;
	logic [BYTE_W-1:0] swap_r;
	logic [FLAG_W-1:0] fl;

	// the four combinations of the operands
	assign cmask_r = ~port.dst & port.src;
	assign mask_r  = port.dst & port.src;
	assign xor_r   = port.dst ^ port.src;
	assign swap_r  = {port.dst[3:0], port.dst[7:4]};

	// result selection and write-back qualifier
	assign port.res = (port.op == ALU_CMASK) ? cmask_r :
	                  (port.op == ALU_MASK)  ? mask_r  :
	                  (port.op == ALU_XOR)   ? xor_r   : swap_r;
	// the two tests only set flags, never the operands
	assign port.wr  = (port.op == ALU_XOR) || (port.op == ALU_SWAP);

	// zero and sign follow the result, others held unless cleared
	always_comb begin
		fl = port.flags_in;                             // c, d, h kept
		fl[FLG_Z] = ~|port.res;
		fl[FLG_S] = port.res[SIGN_BIT];
		if (port.op != ALU_SWAP) begin
			fl[FLG_V] = 1'b0;
		end
	end
	assign port.flags_out = fl;

endmodule

// ===== core/ltx_alu_if.sv
// operand and result bundle between the sequencer and the combining unit
`timescale 1ns/10ps
interface ltx_alu_if;
	import ltx_pkg::*;
	ltx_alu_op_type     op;
	logic [BYTE_W-1:0]  dst;
	logic [BYTE_W-1:0]  src;
	logic [FLAG_W-1:0]  flags_in;
	logic [BYTE_W-1:0]  res;
	logic [FLAG_W-1:0]  flags_out;
	logic               wr;
	modport unit (input op, dst, src, flags_in, output res, flags_out, wr);
	modport core (output op, dst, src, flags_in, input res, flags_out, wr);
endinterface

// ===== core/ltx_pkg.sv
// shared constants and types of the logic-test, exclusive-or and wait slice
package ltx_pkg;

	// bus and datapath widths
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int BYTE_W = 8;
	localparam int FLAG_W = 6;
	localparam int CYC_W  = 3;
	localparam int CNT_W  = 16;

	// opcode families (high nibble) and addressing forms (low nibble)
	localparam logic [3:0] OPH_CMASK = 4'h6;
	localparam logic [3:0] OPH_MASK  = 4'h7;
	localparam logic [3:0] OPH_XOR   = 4'hB;
	localparam logic [3:0] MODE_WW   = 4'h2;
	localparam logic [3:0] MODE_WIND = 4'h3;
	localparam logic [3:0] MODE_GG   = 4'h4;
	localparam logic [3:0] MODE_GIND = 4'h5;
	localparam logic [3:0] MODE_GIMM = 4'h6;

	// single opcodes
	localparam logic [7:0] OP_SWAP_REG = 8'hF0;
	localparam logic [7:0] OP_SWAP_IND = 8'hF1;
	localparam logic [7:0] OP_WAIT     = 8'h3F;

	// cycle counts per instruction
	localparam logic [2:0] CYC_SHORT = 3'h4;
	localparam logic [2:0] CYC_LONG  = 3'h6;
	localparam logic [2:0] CYC_SLOT  = 3'h4;
	localparam logic [2:0] CYC_BAD   = 3'h1;

	// flag bit positions on the flag buses
	localparam int FLG_C    = 0;
	localparam int FLG_Z    = 1;
	localparam int FLG_S    = 2;
	localparam int FLG_V    = 3;
	localparam int FLG_D    = 4;
	localparam int FLG_H    = 5;
	localparam int SIGN_BIT = 7;

	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_COUNT  = 8'h08;

	// register fields and reset values
	localparam int         CTRL_EN_BIT = 0;
	localparam int         CTRL_RP_LSB = 8;
	localparam int         ST_RES_LSB  = 0;
	localparam int         ST_FLG_LSB  = 8;
	localparam int         ST_BUSY_BIT = 16;
	localparam int         ST_WAIT_BIT = 17;
	localparam int         ST_BAD_BIT  = 18;
	localparam logic       EN_RST      = 1'b1;
	localparam logic [7:0] RP_RST      = 8'h00;

	// response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {ALU_CMASK, ALU_MASK, ALU_XOR, ALU_SWAP} ltx_alu_op_type;
	typedef enum logic [2:0] {
		ST_IDLE, ST_PTR, ST_SRC, ST_DST, ST_WB, ST_PAD, ST_WAIT
	} ltx_state_type;
	typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_COUNT, SEL_NONE} ltx_sel_type;

endpackage

// ===== core/ltx_top.sv
// sequencer, operand fetch, wait state and register slave of the slice
// Functional notes
// - complement-and-mask test: not dst and src, flags only
// - its flags: z, s bit 7, v cleared
// - opcodes 62 to 66, bytes and cycles
// - mask test: dst and src, flags only
// - its flags: z, s bit 7, v cleared
// - opcodes 72 to 76, bytes and cycles
// - exclusive-or writes dst xor src to dst
// - its flags: z, s bit 7, v cleared
// - opcodes B2 to B6, bytes and cycles
// - F1 swaps the pointed register, 4 cycles
// - wait halts until internal interrupt, dma allowed
// - opcode 3F, lasts whole 4-cycle slots
// - swap exchanges low and high nibbles
// - swap flags: z, s bit 7, d h kept
`timescale 1ns/10ps
module ltx_top (
	input  logic                        clock,
	input  logic                        rstn,
	input  logic [ltx_pkg::ADDR_W-1:0]  s_axi_awaddr,
	input  logic                        s_axi_awvalid,
	output logic                        s_axi_awready,
	input  logic [ltx_pkg::DATA_W-1:0]  s_axi_wdata,
	input  logic [3:0]                  s_axi_wstrb,
	input  logic                        s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  logic                        s_axi_bready,
	input  logic [ltx_pkg::ADDR_W-1:0]  s_axi_araddr,
	input  logic                        s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [ltx_pkg::DATA_W-1:0]  s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  logic                        s_axi_rready,
	input  logic                        ins_valid,
	output logic                        ins_ready,
	input  logic [ltx_pkg::BYTE_W-1:0]  ins_opcode,
	input  logic [ltx_pkg::BYTE_W-1:0]  ins_byte1,
	input  logic [ltx_pkg::BYTE_W-1:0]  ins_byte2,
	output logic                        ins_done,
	output logic [ltx_pkg::BYTE_W-1:0]  rf_raddr,
	input  logic [ltx_pkg::BYTE_W-1:0]  rf_rdata,
	output logic                        rf_we,
	output logic [ltx_pkg::BYTE_W-1:0]  rf_waddr,
	output logic [ltx_pkg::BYTE_W-1:0]  rf_wdata,
	input  logic [ltx_pkg::FLAG_W-1:0]  flags_in,
	output logic [ltx_pkg::FLAG_W-1:0]  flags_out,
	output logic                        flags_we,
	input  logic                        irq_event,
	output logic                        cpu_halted
);
	import ltx_pkg::*;

	// two-operand family with a known addressing form
	function automatic logic f_logic(input logic [7:0] op);
		logic fam;
		fam = (op[7:4] == OPH_CMASK) || (op[7:4] == OPH_MASK) || (op[7:4] == OPH_XOR);
		return fam && (op[3:0] >= MODE_WW) && (op[3:0] <= MODE_GIMM);
	endfunction

	// total cycles of an accepted opcode
	function automatic logic [2:0] f_cycles(input logic [7:0] op);
		if (f_logic(op)) begin
			return (op[3:0] == MODE_WW) ? CYC_SHORT : CYC_LONG;
		end
		if ((op == OP_SWAP_REG) || (op == OP_SWAP_IND)) begin
			return CYC_SHORT;
		end
		if (op == OP_WAIT) begin
			return CYC_SLOT;
		end
		return CYC_BAD;
	endfunction

	// first micro step of an accepted opcode
	function automatic ltx_state_type f_first(input logic [7:0] op);
		if (f_logic(op)) begin
			case (op[3:0])
				MODE_WIND, MODE_GIND: return ST_PTR;
				MODE_GIMM:            return ST_DST;
				default:              return ST_SRC;
			endcase
		end
		if (op == OP_SWAP_IND) begin
			return ST_PTR;
		end
		if (op == OP_SWAP_REG) begin
			return ST_DST;
		end
		if (op == OP_WAIT) begin
			return ST_WAIT;
		end
		return ST_PAD;
	endfunction

	// working register field to register-file address
	function automatic logic [7:0] f_wreg(input logic [3:0] r, input logic [7:0] rp);
		return {rp[7:4], r};
	endfunction

	// register offset decode, shared by reads and writes
	function automatic ltx_sel_type f_sel(input logic [7:0] a);
		if (a[7:2] == OFF_CTRL[7:2]) begin
			return SEL_CTRL;
		end
		if (a[7:2] == OFF_STATUS[7:2]) begin
			return SEL_STATUS;
		end
		if (a[7:2] == OFF_COUNT[7:2]) begin
			return SEL_COUNT;
		end
		return SEL_NONE;
	endfunction

	ltx_state_type      st_q;
	ltx_state_type      st_d;
	logic [CYC_W-1:0]   cyc_q;
	logic [CYC_W-1:0]   tot_q;
	logic [BYTE_W-1:0]  op_q;
	logic [BYTE_W-1:0]  b1_q;
	logic [BYTE_W-1:0]  b2_q;
	logic [BYTE_W-1:0]  ptr_q;
	logic [BYTE_W-1:0]  src_q;
	logic [BYTE_W-1:0]  dst_q;
	logic [BYTE_W-1:0]  daddr_q;
	logic [BYTE_W-1:0]  res_q;
	logic               we_q;
	logic [BYTE_W-1:0]  waddr_q;
	logic [BYTE_W-1:0]  wdata_q;
	logic [FLAG_W-1:0]  flags_q;
	logic               fwe_q;
	logic               pend_q;
	logic               bad_q;
	logic [CNT_W-1:0]   cnt_q;
	logic               en_q;
	logic [BYTE_W-1:0]  rp_q;
	logic               aw_q;
	logic [ADDR_W-1:0]  awaddr_q;
	logic               w_q;
	logic [DATA_W-1:0]  wd_q;
	logic [3:0]         ws_q;
	logic               bvalid_q;
	logic [1:0]         bresp_q;
	logic               rvalid_q;
	logic [1:0]         rresp_q;
	logic [DATA_W-1:0]  rdata_q;
	logic [DATA_W-1:0]  status_w;

	ltx_alu_if alu ();

	ltx_alu u_alu (
		.port (alu.unit)
	);

	// operand decode of the held instruction
	wire [3:0] mode      = op_q[3:0];
	wire       is_swap   = (op_q[7:4] == OP_SWAP_REG[7:4]);
	wire       wide_form = (mode == MODE_GG) || (mode == MODE_GIND);
	wire [7:0] ptr_addr  = (mode == MODE_WIND) ? f_wreg(b1_q[3:0], rp_q) : b1_q;
	// three-byte register forms carry the source byte first
	wire [7:0] src_addr  = (mode == MODE_WW) ? f_wreg(b1_q[3:0], rp_q) :
	                       (mode == MODE_GG) ? b1_q : ptr_q;
	wire [7:0] dst_addr  = is_swap ? ((op_q == OP_SWAP_IND) ? ptr_q : b1_q) :
	                       (mode <= MODE_WIND) ? f_wreg(b1_q[7:4], rp_q) :
	                       wide_form ? b2_q : b1_q;

	// register-file read address per micro step
	assign rf_raddr = (st_q == ST_PTR) ? ptr_addr :
	                  (st_q == ST_SRC) ? src_addr : dst_addr;

	// operation selected for the combining unit
	assign alu.op       = is_swap                 ? ALU_SWAP  :
	                      (op_q[7:4] == OPH_XOR)  ? ALU_XOR   :
	                      (op_q[7:4] == OPH_MASK) ? ALU_MASK  : ALU_CMASK;
	assign alu.dst      = dst_q;
	assign alu.src      = src_q;
	assign alu.flags_in = flags_in;

	// handshake and timing terms
	wire accept   = ins_valid && ins_ready;
	wire last     = (cyc_q == tot_q - 3'h1);
	wire slot_end = (cyc_q == CYC_SLOT - 3'h1);
	wire in_wait  = (st_q == ST_WAIT);
	wire release_wait = in_wait && slot_end && (pend_q || irq_event);
	wire finish   = ((st_q == ST_PAD) && last) || release_wait;
	wire bad_op   = accept && (f_first(ins_opcode) == ST_PAD);

	assign ins_ready  = (st_q == ST_IDLE) && en_q;
	assign ins_done   = finish;
	// fetch is halted while waiting; the dma engine keeps the bus
	assign cpu_halted = in_wait;

	// micro step sequence
	always_comb begin
		st_d = st_q;
		case (st_q)
			ST_IDLE: begin
				if (accept) begin
					st_d = f_first(ins_opcode);
				end
			end
			ST_PTR:  st_d = is_swap ? ST_DST : ST_SRC;
			ST_SRC:  st_d = ST_DST;
			ST_DST:  st_d = ST_WB;
			ST_WB:   st_d = ST_PAD;
			ST_PAD: begin
				if (last) begin
					st_d = ST_IDLE;
				end
			end
			ST_WAIT: begin
				if (release_wait) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// state and cycle count; the wait repeats whole slots
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_q  <= ST_IDLE;
			cyc_q <= '0;
			tot_q <= CYC_BAD;
		end else begin
			st_q <= st_d;
			if (accept) begin
				cyc_q <= '0;
				tot_q <= f_cycles(ins_opcode);
			end else if (in_wait && slot_end) begin
				cyc_q <= '0;
			end else if (st_q != ST_IDLE) begin
				cyc_q <= cyc_q + 3'h1;
			end
		end
	end

	// instruction bytes and fetched operands
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			op_q    <= '0;
			b1_q    <= '0;
			b2_q    <= '0;
			ptr_q   <= '0;
			src_q   <= '0;
			dst_q   <= '0;
			daddr_q <= '0;
		end else begin
			if (accept) begin
				op_q <= ins_opcode;
				b1_q <= ins_byte1;
				b2_q <= ins_byte2;
				src_q <= ins_byte2;                                  // immediate
			end
			if (st_q == ST_PTR) begin
				ptr_q <= rf_rdata;
			end
			if (st_q == ST_SRC) begin
				src_q <= rf_rdata;
			end
			if (st_q == ST_DST) begin
				dst_q   <= rf_rdata;
				daddr_q <= rf_raddr;
			end
		end
	end

	// write-back of result and flags, one cycle after combining
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			we_q    <= 1'b0;
			fwe_q   <= 1'b0;
			waddr_q <= '0;
			wdata_q <= '0;
			res_q   <= '0;
			flags_q <= '0;
		end else begin
			we_q  <= (st_q == ST_WB) && alu.wr;
			fwe_q <= (st_q == ST_WB);
			if (st_q == ST_WB) begin
				waddr_q <= daddr_q;
				wdata_q <= alu.res;
				res_q   <= alu.res;
				flags_q <= alu.flags_out;
			end
		end
	end

	assign rf_we     = we_q;
	assign rf_waddr  = waddr_q;
	assign rf_wdata  = wdata_q;
	assign flags_we  = fwe_q;
	assign flags_out = flags_q;

	// write address and data are taken independently
	wire         wr_fire = aw_q && w_q && !bvalid_q;
	ltx_sel_type wsel;
	assign wsel          = f_sel(awaddr_q);

	// interrupt pending while waiting, bad opcode sticky, done count
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pend_q <= 1'b0;
			bad_q  <= 1'b0;
			cnt_q  <= '0;
		end else begin
			pend_q <= (in_wait && irq_event) || (pend_q && !release_wait);
			bad_q  <= bad_op || (bad_q && !(wr_fire && wsel == SEL_STATUS &&
			          ws_q[ST_BAD_BIT / 8] && wd_q[ST_BAD_BIT]));
			if (finish) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	// each slot is free again once the response has been taken
	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready  = !w_q && !bvalid_q;

	// write channel holding registers and response
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			aw_q     <= 1'b0;
			awaddr_q <= '0;
			w_q      <= 1'b0;
			wd_q     <= '0;
			ws_q     <= '0;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q     <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_q <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q  <= 1'b1;
				wd_q <= s_axi_wdata;
				ws_q <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp  = bresp_q;

	// control register: enable and register pointer, per byte lane
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			en_q <= EN_RST;
			rp_q <= RP_RST;
		end else if (wr_fire && wsel == SEL_CTRL) begin
			if (ws_q[0]) begin
				en_q <= wd_q[CTRL_EN_BIT];
			end
			if (ws_q[1]) begin
				rp_q <= wd_q[CTRL_RP_LSB +: BYTE_W];
			end
		end
	end

	// status word assembled from live state
	always_comb begin
		status_w = '0;
		status_w[ST_RES_LSB +: BYTE_W] = res_q;
		status_w[ST_FLG_LSB +: FLAG_W] = flags_q;
		status_w[ST_BUSY_BIT]          = (st_q != ST_IDLE);
		status_w[ST_WAIT_BIT]          = in_wait;
		status_w[ST_BAD_BIT]           = bad_q;
	end

	// read data selection
	ltx_sel_type rsel;
	assign rsel = f_sel(s_axi_araddr);
	wire [DATA_W-1:0] rd_val =
		(rsel == SEL_CTRL)   ? {16'h0000, rp_q, 7'h00, en_q} :
		(rsel == SEL_STATUS) ? status_w :
		(rsel == SEL_COUNT)  ? {16'h0000, cnt_q} : 32'h0000_0000;
	assign s_axi_arready = !rvalid_q;

	// read channel: one answer per address, held until taken
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= '0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_val;
			rresp_q  <= (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata  = rdata_q;
	assign s_axi_rresp  = rresp_q;

endmodule

// ===== testbench/logic_test_xor_alu_test.sv
// self-checking bench of the logic-test, exclusive-or and wait slice
`timescale 1ns/10ps
module logic_test_xor_alu_test;
	import ltx_pkg::*;
	typedef struct packed {
		logic we; logic fw; logic [7:0] a, d; logic [5:0] f; logic [7:0] n;
	} ltx_exp_type;
	typedef struct packed {logic [31:0] m; logic [1:0] r; logic [31:0] d;} ltx_bus_type;
	logic        clock, rstn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, ins_valid, ins_ready, ins_done, rf_we, flags_we;
	logic        irq_event, cpu_halted, we_s = 1'b0, fw_s = 1'b0;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, ins_opcode, ins_byte1, ins_byte2;
	logic [7:0]  rf_raddr, rf_rdata, rf_waddr, rf_wdata, rp, x, mem_e [256];
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, bq [$];
	logic [5:0]  flags_in, flags_out, fl_e;
	logic [3:0]  fam [3] = '{OPH_CMASK, OPH_MASK, OPH_XOR};
	int          n_mismatch, comparisons, cnt, n_ins;
	ltx_exp_type eq [$];
	ltx_bus_type rq [$];

	ltx_top dut (.*);
	ltx_rf_model model (.clock, .rf_raddr, .rf_rdata, .rf_we, .rf_waddr, .rf_wdata,
		.flags_out, .flags_we, .flags_in);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic check(string nm, logic [31:0] e, logic [31:0] s);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// takes the oldest note whenever an instruction or bus answer completes
	always @(posedge clock) begin
		ltx_exp_type e;
		ltx_bus_type b;
		cnt++;
		// write pulses may come in the same cycle as the done pulse or earlier
		we_s = we_s || (rf_we === 1'b1);
		fw_s = fw_s || (flags_we === 1'b1);
		if (ins_done === 1'b1) begin
			e = eq.pop_front();
			check("cycles", e.n, cnt);
			check("rf_we", e.we, we_s);
			check("flags_we", e.fw, fw_s);
			we_s = 1'b0;
			fw_s = 1'b0;
			if (e.we) begin
				check("rf_waddr", e.a, rf_waddr);
				check("rf_wdata", e.d, rf_wdata);
			end
			if (e.fw)
				check("flags", e.f, flags_out);
		end
		if (ins_valid && ins_ready)
			cnt = 0;
		if (s_axi_rvalid && s_axi_rready) begin
			b = rq.pop_front();
			check("rresp", b.r, s_axi_rresp);
			check("rdata", b.d, s_axi_rdata & b.m);
		end
		if (s_axi_bvalid && s_axi_bready)
			check("bresp", bq.pop_front(), s_axi_bresp);
	end

	task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r);
		bq.push_back(r);
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(logic [7:0] a, logic [31:0] m, logic [31:0] d, logic [1:0] r);
		rq.push_back('{m, r, d & m});
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	// notes the expected outcome from the mirror, then offers the instruction
	task automatic run(logic [7:0] op, logic [7:0] b1, logic [7:0] b2, int n, logic alu);
		ltx_exp_type e;
		logic [7:0] d, s, r;
		logic [3:0] md;
		logic [5:0] f;
		md = op[3:0];
		d = (md == MODE_WW || md == MODE_WIND) ? {rp[7:4], b1[7:4]} : (md == MODE_GIMM ? b1 : b2);
		s = (md == MODE_WW) ? mem_e[{rp[7:4], b1[3:0]}] : (md == MODE_WIND) ?
			mem_e[mem_e[{rp[7:4], b1[3:0]}]] : (md == MODE_GG) ? mem_e[b1] :
			(md == MODE_GIND) ? mem_e[mem_e[b1]] : b2;
		if (op == OP_SWAP_REG)
			d = b1;
		if (op == OP_SWAP_IND)
			d = mem_e[b1];
		case (op[7:4])
			OPH_CMASK: r = ~mem_e[d] & s;
			OPH_MASK: r = mem_e[d] & s;
			OPH_XOR: r = mem_e[d] ^ s;
			default: r = {mem_e[d][3:0], mem_e[d][7:4]};
		endcase
		f = fl_e;
		f[FLG_Z] = (r == 8'h00);
		f[FLG_S] = r[SIGN_BIT];
		if (op[7:4] != 4'hF)
			f[FLG_V] = 1'b0;
		e = '{alu && op[7:5] != 3'h3, alu, d, r, f, 8'(n)};
		if (alu)
			fl_e = f;
		if (e.we)
			mem_e[d] = r;
		eq.push_back(e);
		n_ins++;
		@(posedge clock);
		ins_opcode <= op;
		ins_byte1 <= b1;
		ins_byte2 <= b2;
		ins_valid <= 1'b1;
		do @(posedge clock); while (ins_ready !== 1'b1);
		ins_valid <= 1'b0;
	endtask

	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		report_and_stop;
	end

	initial begin
		{rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{ins_valid, irq_event, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{ins_opcode, ins_byte1, ins_byte2} = '0;
		s_axi_wstrb = 4'hF;
		void'($urandom(45));
		for (int i = 0; i < 256; i++) begin
			mem_e[i] = 8'($urandom);
			model.mem[i] = mem_e[i];
		end
		fl_e = 6'($urandom);
		model.flg = fl_e;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		rd(OFF_CTRL, 32'h0000FF01, 32'h00000001, RESP_OKAY);
		rd(8'h0C, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
		wr(8'h0C, 32'h5A, RESP_SLVERR);
		wr(OFF_COUNT, 32'h5A, RESP_OKAY);
		wr(OFF_CTRL, 32'h0, RESP_OKAY);
		@(posedge clock);
		check("ins_ready", 1'b0, ins_ready);
		rp = 8'($urandom);
		wr(OFF_CTRL, {16'h0, rp, 8'h01}, RESP_OKAY);
		// every family in every form, issued back to back
		foreach (fam[i])
			for (int m = 2; m <= 6; m++)
				run({fam[i], 4'(m)}, 8'($urandom), 8'($urandom), m == 2 ? 4 : 6,
					1'b1);
		// immediates chosen so that every family gives a zero result
		foreach (fam[i]) begin
			x = 8'($urandom);
			run({fam[i], MODE_GIMM}, x, fam[i] == OPH_MASK ? ~mem_e[x] : mem_e[x],
				6, 1'b1);
		end
		x = 8'($urandom);
		run(OP_SWAP_REG, x, 8'h00, 4, 1'b1);
		run(OP_SWAP_IND, x, 8'h00, 4, 1'b1);
		// an interrupt during the indirect swap is lost; then waits of one and two slots
		@(posedge clock);
		irq_event <= 1'b1;
		@(posedge clock);
		irq_event <= 1'b0;
		for (int k = 1; k <= 2; k++) begin
			run(OP_WAIT, 8'h00, 8'h00, 4 * k, 1'b0);
			repeat (4 * k - 3) @(posedge clock);
			irq_event <= 1'b1;
			@(posedge clock);
			irq_event <= 1'b0;
		end
		// let the second wait finish before the done count is read
		repeat (2) @(posedge clock);
		rd(OFF_COUNT, 32'h0000FFFF, n_ins, RESP_OKAY);
		run(8'h67, 8'h00, 8'h00, 1, 1'b0);
		rd(OFF_STATUS, 32'h00040000, 32'h00040000, RESP_OKAY);
		wr(OFF_STATUS, 32'h00040000, RESP_OKAY);
		rd(OFF_STATUS, 32'h00040000, 32'h0, RESP_OKAY);
		repeat (4) @(posedge clock);
		check("notes left", 32'h0, eq.size() + rq.size() + bq.size());
		report_and_stop;
	end
endmodule

// ===== testbench/ltx_checker.sv
// concurrent checks on the instruction and register-file ports of the slice
`timescale 1ns/10ps
module ltx_checker
	import ltx_pkg::*;
(
	input logic              clock,
	input logic              rstn,
	input logic              ins_valid,
	input logic              ins_ready,
	input logic [BYTE_W-1:0] ins_opcode,
	input logic              ins_done,
	input logic              rf_we,
	input logic [BYTE_W-1:0] rf_wdata,
	input logic [FLAG_W-1:0] flags_in,
	input logic [FLAG_W-1:0] flags_out,
	input logic              flags_we,
	input logic              irq_event,
	input logic              cpu_halted
);
	logic [7:0] op_q;
	logic [7:0] wcnt_q;
	wire        take    = ins_valid && ins_ready;
	wire        is_swap = op_q[7:1] == 7'h78;

	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);

	// opcode of the running instruction and cycles since it was taken
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			op_q   <= 8'h00;
			wcnt_q <= 8'h00;
		end else begin
			op_q   <= take ? ins_opcode : op_q;
			wcnt_q <= take ? 8'h00 : wcnt_q + 8'h01;
		end
	end

	a_test_nowrite: assert property (
		take && ins_opcode[7:5] == 3'h3 |=> !rf_we [*6])
		else $error("mask test wrote the register file");
	a_short_len: assert property (
		take && (ins_opcode inside {8'h62, 8'h72, 8'hB2, 8'hF0, 8'hF1})
		|=> !ins_done [*3] ##1 ins_done)
		else $error("short form did not end in its fourth cycle");
	a_long_len: assert property (
		take && (ins_opcode[7:4] inside {4'h6, 4'h7, 4'hB})
		&& (ins_opcode[3:0] inside {[4'h3:4'h6]}) |=> !ins_done [*5] ##1 ins_done)
		else $error("long form did not end in its sixth cycle");
	a_v_cleared: assert property (
		flags_we && !is_swap |-> !flags_out[FLG_V])
		else $error("overflow not cleared");
	a_dhc_kept: assert property (
		flags_we |-> flags_out[FLG_H:FLG_D] == flags_in[FLG_H:FLG_D]
		&& flags_out[FLG_C] == flags_in[FLG_C])
		else $error("carry, decimal or half carry changed");
	a_zs_result: assert property (
		rf_we |-> flags_we && flags_out[FLG_S] == rf_wdata[SIGN_BIT]
		&& flags_out[FLG_Z] == (rf_wdata == 8'h00))
		else $error("zero or sign flag does not match the result");
	a_wait_halt: assert property (
		take && ins_opcode == OP_WAIT |=> cpu_halted)
		else $error("wait did not halt");
	a_wait_quiet: assert property (
		cpu_halted |-> !flags_we && !rf_we)
		else $error("write during wait");
	a_wait_slot: assert property (
		ins_done && cpu_halted |-> wcnt_q[1:0] == 2'h3)
		else $error("wait ended off a four-cycle slot");
	a_wait_wake: assert property (
		cpu_halted && irq_event |-> ##[0:3] ins_done)
		else $error("interrupt did not end the wait");
endmodule

bind ltx_top ltx_checker chk (.clock, .rstn, .ins_valid, .ins_ready, .ins_opcode, .ins_done,
	.rf_we, .rf_wdata, .flags_in, .flags_out, .flags_we, .irq_event, .cpu_halted);

// ===== testbench/ltx_rf_model.sv
// register file and flag register standing behind the slice
`timescale 1ns/10ps
module ltx_rf_model (
	input  logic       clock,
	input  logic [7:0] rf_raddr,
	output logic [7:0] rf_rdata,
	input  logic       rf_we,
	input  logic [7:0] rf_waddr,
	input  logic [7:0] rf_wdata,
	input  logic [5:0] flags_out,
	input  logic       flags_we,
	output logic [5:0] flags_in
);
	logic [7:0] mem [256];
	logic [5:0] flg;
	// read is asynchronous: the slice wants the byte in the same cycle
	assign rf_rdata = mem[rf_raddr];
	assign flags_in = flg;
	// writes land at the clock edge
	always @(posedge clock) begin
		if (rf_we)
			mem[rf_waddr] <= rf_wdata;
		if (flags_we)
			flg <= flags_out;
	end
endmodule
